// ==== hrap_defines.svh ====
// constants of the host register access port
`ifndef HRAP_DEFINES_SVH
`define HRAP_DEFINES_SVH
`define CLK_HZ 250000000
`define SER_TIMEOUT_MS 32
`define SER_TIMEOUT_CYCLES (`SER_TIMEOUT_MS * (`CLK_HZ / 1000))
`define REG_ADDR_W 7
`define REG_SPACE 128
`define CMD_RD_BIT 7
`define ACK_ERR_BIT 7
`define SER_MAX_DATA 6
`define TX_FIFO_DEPTH 32
`define BYTE_BITS 8
`define PAR_PIN_RST 12'hfff
`define SPI_PIN_RST 3'h2
`endif

// ==== hrap_pkg.sv ====
// types of the host register access port
package hrap_pkg;
    typedef logic [6:0] reg_addr_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [3:0] {
        SER_CMD, SER_CNT, SER_DATA, SER_SUM, SER_WR, SER_ACK, SER_RD, SER_RDW, SER_PUSH, SER_CK
    } ser_state_t;
endpackage : hrap_pkg

// ==== pin_sync.sv ====
// three-stage pin synchroniser, output follows once stages two and three agree
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins and result
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_nxt;

    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("pin_sync width must be at least one");
        end
    endgenerate

    // per bit: take the new value only when two later stages match
    assign level_nxt = (s2_r & ~(s2_r ^ s3_r)) | (level & (s2_r ^ s3_r));

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level <= RST_VAL;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level <= level_nxt;
        end
    end
endmodule : pin_sync

// ==== tx_fifo.sv ====
// byte fifo with a registered output stage, valid and ready on both sides
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pull;

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_chk
            $error("tx_fifo depth must be a power of two of at least two");
        end
    endgenerate

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pull = (cnt_r != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            wptr_r <= wptr_r + AW'(push);
            rptr_r <= rptr_r + AW'(pull);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pull);
            if (pull)
            begin
                out_data <= mem[rptr_r];
                out_valid <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule : tx_fifo

// ==== host_register_access_port.sv ====
// host access front end: parallel, spi and serial paths into one register window
//
// Behaviour
// [RULE1] parallel, spi and serial all live, all reach the same registers
// [RULE2] registers sit in one 128-byte window, 7-bit start address
// [RULE3] parallel byte with address select high loads the pointer
// [RULE4] parallel data byte, read or write, increments the pointer
// [RULE5] host may send a new address byte between data bytes
// [RULE6] spi command byte first: bit 7 read-only, bits 6..0 start address
// [RULE7] spi starts at command address, advances per data byte until deselect
// [RULE8] serial write: command, count, one to six data bytes, checksum
// [RULE9] serial command bit 7 one reads, zero writes; bits 6..0 address
// [RULE10] serial checksum is low byte of sum of all preceding frame bytes
// [RULE11] serial write: check checksum, store bytes consecutively, then acknowledge
// [RULE12] acknowledge byte: bit 7 error, bits 6..0 start address, then checksum
// [RULE13] serial read: command, count, checksum; reply ack, data, checksum
// [RULE14] failed serial read replies only error ack and checksum
// [RULE15] serial request not complete within 32 ms is abandoned
// [RULE16] host resends a write after an error acknowledge
// [RULE17] host resends a read when no reply arrives
// [RULE18] parallel write keeps output enable high while selected
// [RULE19] host settles output and write enables before selecting
// [RULE20] abandoned request gets no ack; next byte is a new command
// [RULE21] bad checksum leaves registers untouched, answers with error ack
`include "hrap_defines.svh"
module host_register_access_port #(
    parameter int TIMEOUT_CYCLES = `SER_TIMEOUT_CYCLES,
    parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // parallel port pins
    input wire logic host_port_select_n,
    input wire logic host_port_output_en_n,
    input wire logic host_port_write_en_n,
    input wire logic host_port_addr_select,
    input wire hrap_pkg::byte_t host_port_bus_in,
    output hrap_pkg::byte_t host_port_bus_out,
    output logic host_port_bus_oe,
    // spi slave pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // serial byte stream
    input wire hrap_pkg::byte_t ser_rx_data,
    input wire logic ser_rx_valid,
    output hrap_pkg::byte_t ser_tx_data,
    output logic ser_tx_valid,
    input wire logic ser_tx_ready,
    // register window
    output hrap_pkg::reg_addr_t reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output hrap_pkg::byte_t reg_wdata,
    input wire hrap_pkg::byte_t reg_rdata
);
    import hrap_pkg::*;

    localparam logic [23:0] TMO_LAST = 24'(TIMEOUT_CYCLES - 1);

    generate
        if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > (1 << 24))
        begin : g_chk
            $error("timeout count out of range");
        end
    endgenerate

    // shared read return
    byte_t rd_data_r;
    logic rd_done_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_data_r <= '0;
            rd_done_r <= 1'b0;
        end
        else
        begin
            rd_done_r <= reg_rd;
            if (reg_rd)
            begin
                rd_data_r <= reg_rdata;
            end
        end
    end

    // parallel port
    logic p_sel_n, p_oe_n, p_we_n, p_a;
    byte_t p_d;
    logic p_sel_prev_r, p_rdwait_r, p_rdcyc_r;
    reg_addr_t p_ptr_r;

    pin_sync #(.WIDTH(12), .RST_VAL(`PAR_PIN_RST)) u_par_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin({host_port_select_n, host_port_output_en_n, host_port_write_en_n, host_port_addr_select,
              host_port_bus_in}),
        .level({p_sel_n, p_oe_n, p_we_n, p_a, p_d})
    );

    wire p_fall = p_sel_prev_r && !p_sel_n;
    wire p_rise = !p_sel_prev_r && p_sel_n;
    // read decided at select fall, write taken at select rise when data is surely settled
    wire p_rd_start = p_fall && !p_oe_n && p_we_n; // [RULE18] [RULE19]
    wire p_wr = p_rise && !p_we_n && !p_a;
    wire p_rd = p_rd_start && !p_a;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            p_sel_prev_r <= 1'b1;
            p_rdwait_r <= 1'b0;
            p_rdcyc_r <= 1'b0;
            p_ptr_r <= '0;
            host_port_bus_out <= '0;
            host_port_bus_oe <= 1'b0;
        end
        else
        begin
            p_sel_prev_r <= p_sel_n;
            if (p_rd_start)
            begin
                p_rdcyc_r <= !p_a;
                p_rdwait_r <= !p_a;
                if (p_a)
                begin
                    host_port_bus_out <= {1'b0, p_ptr_r};
                    host_port_bus_oe <= 1'b1;
                end
            end
            else if (p_rdwait_r && rd_done_r)
            begin
                host_port_bus_out <= rd_data_r;
                host_port_bus_oe <= 1'b1;
                p_rdwait_r <= 1'b0;
            end
            if (p_rise)
            begin
                host_port_bus_oe <= 1'b0;
                p_rdwait_r <= 1'b0;
                p_rdcyc_r <= 1'b0;
                if (!p_we_n && p_a)
                begin
                    p_ptr_r <= p_d[6:0]; // [RULE3] [RULE5]
                end
                else if (p_wr || p_rdcyc_r)
                begin
                    p_ptr_r <= p_ptr_r + 7'h01; // [RULE4]
                end
            end
        end
    end

    // spi slave, mode 0: sample on rising, shift on falling
    logic k_sclk, k_cs_n, k_mosi;
    logic k_sclk_prev_r, k_first_r, k_ronly_r, k_rdpend_r;
    logic [2:0] k_bit_r;
    byte_t k_in_r, k_out_r, k_next_r;
    reg_addr_t k_ptr_r;

    pin_sync #(.WIDTH(3), .RST_VAL(`SPI_PIN_RST)) u_spi_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin({spi_sclk, spi_cs_n, spi_mosi}),
        .level({k_sclk, k_cs_n, k_mosi})
    );

    wire k_rise = !k_sclk_prev_r && k_sclk && !k_cs_n;
    wire k_fall = k_sclk_prev_r && !k_sclk && !k_cs_n;
    wire k_byte_done = k_rise && (k_bit_r == 3'h7);
    wire [7:0] k_byte = {k_in_r[6:0], k_mosi};
    wire k_wr = k_byte_done && !k_first_r && !k_ronly_r; // [RULE6]
    wire k_rd = k_rdpend_r && !k_wr;
    wire reg_addr_t k_addr = k_wr ? k_ptr_r : k_ptr_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst || k_cs_n)
        begin
            k_sclk_prev_r <= 1'b0;
            k_first_r <= 1'b1;
            k_ronly_r <= 1'b0;
            k_rdpend_r <= 1'b0;
            k_bit_r <= '0;
            k_in_r <= '0;
            k_out_r <= '0;
            k_next_r <= '0;
            k_ptr_r <= '0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            k_sclk_prev_r <= k_sclk;
            spi_miso_oe <= 1'b1;
            if (k_rise)
            begin
                k_in_r <= k_byte;
                k_bit_r <= k_bit_r + 3'h1;
            end
            if (k_byte_done)
            begin
                k_first_r <= 1'b0;
                if (k_first_r)
                begin
                    k_ronly_r <= k_byte[`CMD_RD_BIT]; // [RULE6]
                    k_ptr_r <= k_byte[6:0]; // [RULE7]
                end
                else
                begin
                    k_ptr_r <= k_ptr_r + 7'h01; // [RULE7]
                end
            end
            // read of the following byte waits one cycle so its write lands first
            if (k_byte_done)
            begin
                k_rdpend_r <= 1'b1;
            end
            else if (k_rd)
            begin
                k_rdpend_r <= 1'b0;
            end
            if (rd_done_r)
            begin
                k_next_r <= rd_data_r;
            end
            if (k_fall)
            begin
                if (k_bit_r == 3'h0)
                begin
                    spi_miso <= k_next_r[7];
                    k_out_r <= {k_next_r[6:0], 1'b0};
                end
                else
                begin
                    spi_miso <= k_out_r[7];
                    k_out_r <= {k_out_r[6:0], 1'b0};
                end
            end
        end
    end

    // serial request engine
    ser_state_t u_state_r, u_state_nxt;
    byte_t u_cmd_r, u_cnt_r, u_idx_r, u_sum_r, u_hold_r;
    byte_t u_buf_r [`SER_MAX_DATA];
    reg_addr_t u_ptr_r;
    logic u_err_r;
    logic [23:0] u_tmo_r;
    logic f_in_ready;

    wire u_read = u_cmd_r[`CMD_RD_BIT]; // [RULE9]
    wire u_last = (u_idx_r == u_cnt_r - 8'h01);
    wire u_busy_rx = (u_state_r == SER_CNT) || (u_state_r == SER_DATA) || (u_state_r == SER_SUM);
    wire u_timeout = u_busy_rx && (u_tmo_r == TMO_LAST); // [RULE15]
    wire u_sum_ok = (ser_rx_data == u_sum_r); // [RULE10]
    wire u_cnt_ok = (u_cnt_r != 8'h00) && (u_read || u_cnt_r <= 8'(`SER_MAX_DATA)); // [RULE8]
    wire u_wr = (u_state_r == SER_WR);
    wire u_rd = (u_state_r == SER_RD);
    wire byte_t u_ack = {u_err_r, u_cmd_r[6:0]}; // [RULE12]
    wire u_push = f_in_ready && ((u_state_r == SER_ACK) || (u_state_r == SER_PUSH) || (u_state_r == SER_CK));
    wire byte_t u_push_data = (u_state_r == SER_ACK) ? u_ack : (u_state_r == SER_PUSH) ? u_hold_r : u_sum_r;

    always_comb
    begin
        u_state_nxt = u_state_r;
        case (u_state_r)
            SER_CMD: if (ser_rx_valid) u_state_nxt = SER_CNT;
            SER_CNT: if (ser_rx_valid) u_state_nxt = (u_read || ser_rx_data == 8'h00) ? SER_SUM : SER_DATA;
            SER_DATA: if (ser_rx_valid && u_last) u_state_nxt = SER_SUM;
            SER_SUM: if (ser_rx_valid) u_state_nxt = (!u_read && u_sum_ok && u_cnt_ok) ? SER_WR : SER_ACK;
            SER_WR: if (u_last) u_state_nxt = SER_ACK;
            SER_ACK: if (f_in_ready) u_state_nxt = (u_read && !u_err_r) ? SER_RD : SER_CK; // [RULE14]
            SER_RD: u_state_nxt = SER_RDW;
            SER_RDW: if (rd_done_r) u_state_nxt = SER_PUSH;
            SER_PUSH: if (f_in_ready) u_state_nxt = u_last ? SER_CK : SER_RD;
            SER_CK: if (f_in_ready) u_state_nxt = SER_CMD;
            default: u_state_nxt = SER_CMD;
        endcase
        if (u_timeout)
        begin
            u_state_nxt = SER_CMD; // [RULE20]
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            u_state_r <= SER_CMD;
            u_cmd_r <= '0;
            u_cnt_r <= '0;
            u_idx_r <= '0;
            u_sum_r <= '0;
            u_hold_r <= '0;
            u_ptr_r <= '0;
            u_err_r <= 1'b0;
            u_tmo_r <= '0;
            for (int i = 0; i < `SER_MAX_DATA; i++)
            begin
                u_buf_r[i] <= '0;
            end
        end
        else
        begin
            u_state_r <= u_state_nxt;
            u_tmo_r <= u_busy_rx ? u_tmo_r + 24'h1 : 24'h0;
            if (ser_rx_valid && u_busy_rx)
            begin
                u_sum_r <= u_sum_r + ser_rx_data; // [RULE10]
            end
            case (u_state_r)
                SER_CMD:
                begin
                    if (ser_rx_valid)
                    begin
                        u_cmd_r <= ser_rx_data;
                        u_sum_r <= ser_rx_data;
                    end
                end
                SER_CNT:
                begin
                    u_cnt_r <= ser_rx_data;
                    u_idx_r <= '0;
                end
                SER_DATA:
                begin
                    if (ser_rx_valid)
                    begin
                        if (u_idx_r < 8'(`SER_MAX_DATA))
                        begin
                            u_buf_r[u_idx_r[2:0]] <= ser_rx_data;
                        end
                        u_idx_r <= u_idx_r + 8'h01;
                    end
                end
                SER_SUM:
                begin
                    u_err_r <= !(u_sum_ok && u_cnt_ok); // [RULE11] [RULE21]
                    u_idx_r <= '0;
                    u_ptr_r <= u_cmd_r[6:0];
                end
                SER_WR:
                begin
                    u_ptr_r <= u_ptr_r + 7'h01; // [RULE11]
                    u_idx_r <= u_idx_r + 8'h01;
                end
                SER_ACK:
                begin
                    u_sum_r <= u_ack;
                    u_idx_r <= '0;
                    u_ptr_r <= u_cmd_r[6:0];
                end
                SER_RDW:
                begin
                    if (rd_done_r)
                    begin
                        u_hold_r <= rd_data_r;
                    end
                end
                SER_PUSH:
                begin
                    if (f_in_ready)
                    begin
                        u_sum_r <= u_sum_r + u_hold_r; // [RULE13]
                        u_ptr_r <= u_ptr_r + 7'h01;
                        u_idx_r <= u_idx_r + 8'h01;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // replies queue here so a slow line stalls the engine instead of dropping bytes
    tx_fifo #(.WIDTH(`BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(u_push),
        .in_ready(f_in_ready),
        .in_data(u_push_data),
        .out_valid(ser_tx_valid),
        .out_ready(ser_tx_ready),
        .out_data(ser_tx_data)
    );

    // one window for all three paths; the host never drives two at once
    wire any_wr = p_wr || k_wr || u_wr; // [RULE1]
    wire any_rd = p_rd || k_rd || u_rd;
    wire reg_addr_t sel_addr = (p_wr || p_rd) ? p_ptr_r : (k_wr || k_rd) ? k_addr : u_ptr_r; // [RULE2]
    wire byte_t sel_wdata = p_wr ? p_d : k_wr ? k_byte : u_buf_r[u_idx_r[2:0]];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_addr <= '0;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_wdata <= '0;
        end
        else
        begin
            reg_wr <= any_wr;
            reg_rd <= any_rd && !any_wr;
            if (any_wr || any_rd)
            begin
                reg_addr <= sel_addr;
                reg_wdata <= sel_wdata;
            end
        end
    end
endmodule : host_register_access_port

// ==== hrap_checker_sva.sv ====
// pin-level assertions for the host register access port
module hrap_checker
    import hrap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // parallel port
    input wire logic host_port_select_n,
    input wire logic host_port_output_en_n,
    input wire logic host_port_write_en_n,
    input wire logic host_port_addr_select,
    input wire logic host_port_bus_oe,
    // spi
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe,
    // serial reply
    input wire hrap_pkg::byte_t ser_tx_data,
    input wire logic ser_tx_valid,
    input wire logic ser_tx_ready,
    // register window
    input wire hrap_pkg::reg_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_wr_rd_apart: assert property (!(reg_wr && reg_rd))
        else $error("register write and read in one cycle");
    a_wr_addr_step: assert property (reg_wr ##1 reg_wr |-> reg_addr == $past(reg_addr) + 7'h01)
        else $error("back to back writes not at consecutive addresses");
    a_addr_no_write: assert property ($rose(host_port_select_n) && !host_port_write_en_n && host_port_addr_select
        |-> !reg_wr [*8])
        else $error("address byte reached a register");
    a_par_wr_lands: assert property ($rose(host_port_select_n) && !host_port_write_en_n && !host_port_addr_select
        |-> ##[2:6] reg_wr)
        else $error("parallel data write never reached the window");
    a_par_rd_fetch: assert property ($fell(host_port_select_n) && !host_port_output_en_n && host_port_write_en_n
        && !host_port_addr_select |-> ##[2:8] reg_rd)
        else $error("parallel data read never fetched a register");
    a_bus_drive_sel: assert property ($rose(host_port_bus_oe)
        |-> !host_port_select_n && !host_port_output_en_n && host_port_write_en_n)
        else $error("parallel bus driven outside a read cycle");
    a_miso_in_frame: assert property ($rose(spi_miso_oe) |-> !spi_cs_n)
        else $error("miso driven while spi deselected");
    a_tx_hold: assert property (ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
        else $error("reply byte dropped or changed while stalled");

    cover property (reg_wr ##1 reg_wr);
    cover property ($rose(host_port_bus_oe));
    cover property (ser_tx_valid && !ser_tx_ready ##1 ser_tx_valid);
endmodule : hrap_checker

bind host_register_access_port hrap_checker chk (.*);

// ==== reg_file_model.sv ====
// register window model: 128 bytes, combinational read
module reg_file_model
    import hrap_pkg::*;
(
    // clock
    input wire logic clk,
    // register window
    input wire hrap_pkg::reg_addr_t reg_addr,
    input wire logic reg_wr,
    input wire hrap_pkg::byte_t reg_wdata,
    output hrap_pkg::byte_t reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    byte_t mem [128];
    initial
    begin
        for (int i = 0; i < 128; i++)
        begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end
    // one window shared by every host path
    assign reg_rdata = mem[reg_addr];
    always @(posedge clk)
    begin
        if (reg_wr)
        begin
            mem[reg_addr] <= reg_wdata;
        end
    end
endmodule : reg_file_model

// ==== host_register_access_port_bench.sv ====
// self-checking bench for the host register access port
module host_register_access_port_bench;
    import hrap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic asel; logic wr; byte_t d; byte_t q;} row_t;
    logic clk = 1'b0, sys_rst = 1'b1;
    logic host_port_select_n = 1'b1, host_port_output_en_n = 1'b1, host_port_write_en_n = 1'b1;
    logic host_port_addr_select = 1'b0, host_port_bus_oe;
    byte_t host_port_bus_in = 8'h00, host_port_bus_out, ser_rx_data = 8'h00, ser_tx_data, reg_wdata, reg_rdata;
    logic spi_sclk = 1'b0, spi_cs_n = 1'b1, spi_mosi = 1'b0, spi_miso, spi_miso_oe;
    logic ser_rx_valid = 1'b0, ser_tx_valid, ser_tx_ready = 1'b1, reg_wr, reg_rd;
    reg_addr_t reg_addr;
    int fail_count = 0, num_checks = 0, cyc = 0;
    byte_t q, got [$], e [$];
    // pointer wraps from 0x7f to 0x00; address-byte read returns the pointer
    row_t rows [13] = '{'{1'b1, 1'b1, 8'h10, 8'h00}, '{1'b0, 1'b1, 8'h11, 8'h00}, '{1'b0, 1'b1, 8'h22, 8'h00},
        '{1'b1, 1'b1, 8'h10, 8'h00}, '{1'b0, 1'b0, 8'h00, 8'h11}, '{1'b0, 1'b0, 8'h00, 8'h22},
        '{1'b0, 1'b0, 8'h00, 8'hb7}, '{1'b1, 1'b1, 8'h7f, 8'h00}, '{1'b0, 1'b1, 8'h77, 8'h00},
        '{1'b0, 1'b0, 8'h00, 8'ha5}, '{1'b1, 1'b0, 8'h00, 8'h01}, '{1'b1, 1'b1, 8'h7f, 8'h00},
        '{1'b0, 1'b0, 8'h00, 8'h77}};

    host_register_access_port #(.TIMEOUT_CYCLES(200)) uut (.*);
    reg_file_model rf (.*);

    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        if (ser_tx_valid === 1'b1 && ser_tx_ready === 1'b1)
            got.push_back(ser_tx_data);
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input byte_t seen, input byte_t exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic par_op(input logic asel, input logic wr, input byte_t d, output byte_t r);
        r = 8'h00;
        @(negedge clk);
        host_port_write_en_n = !wr;
        host_port_output_en_n = wr;
        host_port_addr_select = asel;
        host_port_bus_in = d;
        @(negedge clk);
        host_port_select_n = 1'b0;
        repeat (20)
        begin
            @(negedge clk);
            if (host_port_bus_oe === 1'b1)
                r = host_port_bus_out;
        end
        host_port_select_n = 1'b1;
        repeat (6) @(negedge clk);
        host_port_write_en_n = 1'b1;
        host_port_output_en_n = 1'b1;
        host_port_bus_in = ~d;
        repeat (6) @(negedge clk);
    endtask : par_op

    task automatic spi_byte(input byte_t tx, output byte_t rx);
        for (int b = 7; b >= 0; b--)
        begin
            spi_mosi = tx[b];
            repeat (16) @(negedge clk);
            spi_sclk = 1'b1;
            rx[b] = spi_miso;
            repeat (16) @(negedge clk);
            spi_sclk = 1'b0;
        end
    endtask : spi_byte

    task automatic spi_xfer(input byte_t cmd, d0, d1, e0, e1);
        byte_t r;
        spi_cs_n = 1'b0;
        repeat (8) @(negedge clk);
        spi_byte(cmd, r);
        spi_byte(d0, r);
        chk("spi byte 0", r, e0);
        spi_byte(d1, r);
        chk("spi byte 1", r, e1);
        repeat (8) @(negedge clk);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (12) @(negedge clk);
    endtask : spi_xfer

    task automatic ser_put(input byte_t b);
        @(negedge clk);
        ser_rx_data = b;
        ser_rx_valid = 1'b1;
        @(negedge clk);
        ser_rx_valid = 1'b0;
        ser_rx_data = ~b;
    endtask : ser_put

    // bad flips bit 0 of the checksum; x is the reply without its checksum
    task automatic ser_txn(input byte_t f [$], input logic bad, input byte_t x [$]);
        byte_t s;
        int n;
        s = 8'h00;
        got.delete();
        foreach (f[i])
        begin
            ser_put(f[i]);
            s += f[i];
        end
        ser_put(s ^ {7'h00, bad});
        s = 8'h00;
        foreach (x[i])
            s += x[i];
        x.push_back(s);
        n = 0;
        while (got.size() < x.size() && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        repeat (20) @(negedge clk);
        chk("reply length", 8'(got.size()), 8'(x.size()));
        foreach (x[i])
            if (i < got.size())
                chk("reply byte", got[i], x[i]);
    endtask : ser_txn

    initial
    begin
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk("idle reply valid", {7'h00, ser_tx_valid}, 8'h00);
        repeat (4) @(negedge clk);
        foreach (rows[r])
        begin
            par_op(rows[r].asel, rows[r].wr, rows[r].d, q);
            if (!rows[r].wr)
                chk("parallel read", q, rows[r].q);
        end
        spi_xfer(8'h05, 8'hc1, 8'hc2, 8'ha0, 8'ha3);
        spi_xfer(8'h85, 8'hff, 8'hff, 8'hc1, 8'hc2);
        spi_xfer(8'h85, 8'h00, 8'h00, 8'hc1, 8'hc2);
        ser_txn('{8'h2f, 8'h02, 8'h00, 8'h04}, 1'b0, '{8'h2f});
        ser_txn('{8'haf, 8'h02}, 1'b0, '{8'h2f, 8'h00, 8'h04});
        ser_txn('{8'h2f, 8'h02, 8'h55, 8'h66}, 1'b1, '{8'haf});
        ser_txn('{8'haf, 8'h02}, 1'b0, '{8'h2f, 8'h00, 8'h04});
        ser_txn('{8'h2f, 8'h02, 8'h55, 8'h66}, 1'b0, '{8'h2f});
        ser_txn('{8'h30, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07}, 1'b0, '{8'hb0});
        ser_txn('{8'ha0, 8'h00}, 1'b0, '{8'ha0});
        got.delete();
        ser_put(8'h2f);
        ser_put(8'h02);
        repeat (250) @(negedge clk);
        chk("abandoned reply", 8'(got.size()), 8'h00);
        ser_txn('{8'haf, 8'h01}, 1'b0, '{8'h2f, 8'h55});
        par_op(1'b1, 1'b1, 8'h2f, q);
        par_op(1'b0, 1'b0, 8'h00, q);
        chk("shared window", q, 8'h55);
        // 42 reply bytes against a 32 deep buffer while the line stalls
        e = '{8'h40};
        for (int i = 0; i < 40; i++)
            e.push_back(8'(8'h40 + i) ^ 8'ha5);
        ser_tx_ready = 1'b0;
        fork
            ser_txn('{8'hc0, 8'h28}, 1'b0, e);
            begin
                repeat (400) @(negedge clk);
                ser_tx_ready = 1'b1;
            end
        join
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        chk("reset outputs", {4'h0, host_port_bus_oe, spi_miso_oe, ser_tx_valid, reg_wr}, 8'h00);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule : host_register_access_port_bench
